/* File: verilog/mcsc_pkg.sv */
/*
 * constants shared by the motion compare and start configuration block:
 * register indices, field positions, reset values and status bit layout.
 * assumes a 32-bit apb with byte addresses equal to four times the index.
 */
package mcsc_pkg;

    // ==========================================================
    // register indices and byte addresses
    localparam logic [5:0]  IDX_REF_CFG    = 6'h01;
    localparam logic [5:0]  IDX_START_CFG  = 6'h02;
    localparam logic [5:0]  IDX_STATUS     = 6'h03;
    localparam logic [5:0]  IDX_MASK       = 6'h04;
    localparam logic [5:0]  IDX_LIVE       = 6'h05;
    localparam logic [7:0]  ADDR_REF_CFG   = {IDX_REF_CFG, 2'b00};
    localparam logic [7:0]  ADDR_START_CFG = {IDX_START_CFG, 2'b00};
    localparam logic [7:0]  ADDR_STATUS    = {IDX_STATUS, 2'b00};
    localparam logic [7:0]  ADDR_MASK      = {IDX_MASK, 2'b00};
    localparam logic [7:0]  ADDR_LIVE      = {IDX_LIVE, 2'b00};

    // ==========================================================
    // reset values
    localparam logic [31:0] REF_CFG_RST    = 32'h00000000;
    localparam logic [31:0] START_CFG_RST  = 32'h00000000;
    localparam logic [3:0]  STATUS_RST     = 4'h0;
    localparam logic [3:0]  MASK_RST       = 4'h0;

    // ==========================================================
    // reference_switch_config field positions
    localparam int GOAL_SEL_LSB    = 23;
    localparam int CMP_SRC_BIT     = 25;
    localparam int STALL_STOP_BIT  = 26;
    localparam int DRV_AFTER_BIT   = 27;
    localparam int CMP_OP_LSB      = 28;
    localparam int AUTO_COVER_BIT  = 30;
    localparam int ENC_WRAP_BIT    = 31;

    // ==========================================================
    // start_trigger_config field positions
    localparam int START_EN_LSB    = 0;
    localparam int SHADOW_BIT      = 4;
    localparam int TRIG_LSB        = 5;
    localparam int START_POL_BIT   = 9;

    // ==========================================================
    // status and mask bit positions
    localparam int ST_CMP_HIT      = 0;
    localparam int ST_STALL        = 1;
    localparam int ST_COVER        = 2;
    localparam int ST_START        = 3;

endpackage

/* File: verilog/mcsc_core.sv */
/*
 * configuration and event logic for position compare, goal pin source,
 * stall stop, automatic cover datagrams, encoder wrap and start triggers,
 * with an apb register slave and a level interrupt.
 * assumes position, velocity and event inputs come from logic on ref_clk;
 * only the start pin input arrives from outside and is synchronised.
 */
// Our own choice: register access over APB.
`timescale 1ns/1ps

module mcsc_core (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // positions and comparator operands
    input  wire logic [31:0] actual_position,
    input  wire logic [31:0] encoder_raw,
    input  wire logic [31:0] wrap_range,
    input  wire logic [31:0] compare_value,
    input  wire logic [31:0] home_position,
    input  wire logic [31:0] latched_position,
    input  wire logic [31:0] encoder_latched,
    input  wire logic [31:0] revolution_counter,
    output logic [31:0]      encoder_position,
    output logic             comparator_hit_flag,
    output logic             comparator_hit_event,
    // ramp flags and events
    input  wire logic        goal_flag,
    input  wire logic        velocity_flag,
    input  wire logic        encoder_fail_flag,
    input  wire logic        goal_event,
    input  wire logic        velocity_event,
    output logic             goal_pin,
    // stall handling
    input  wire logic        stall_event,
    output logic             spi_hard_stop,
    output logic             step_hard_stop,
    output logic             motion_enable,
    // automatic cover datagrams
    input  wire logic [31:0] actual_velocity,
    input  wire logic [31:0] datagram_switch_velocity,
    output logic             cover_request,
    // start configuration
    output logic [3:0]       change_needs_start,
    output logic             shadow_enable,
    output logic             timing_enable,
    output logic             start_trigger,
    // start pin
    input  wire logic        start_pin_in,
    output logic             start_pin_out,
    output logic             start_pin_oe_n,
    // interrupt
    output logic             irq
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0] ref_cfg;
        logic [31:0] start_cfg;
        logic [3:0]  status;
        logic [3:0]  mask;
        logic [31:0] rdata;
        logic [31:0] enc_pos;
        logic        stall_active;
        logic        cmp_flag;
        logic        cmp_event;
        logic        cover_zone;
        logic        cover_req;
        logic        start_meta;
        logic        start_sync;
        logic        start_prev;
        logic        start_pulse;
        logic        pin_out;
        logic        goal_out;
        logic        hard_stop;
    } mcsc_state_s;

    mcsc_state_s s;
    mcsc_state_s next_s;

    // ==========================================================
    // helpers
    // true when the byte address hits a register of this block
    function automatic logic mcsc_mapped(input logic [7:0] a);
        mcsc_mapped = (a == mcsc_pkg::ADDR_REF_CFG) || (a == mcsc_pkg::ADDR_START_CFG) ||
                      (a == mcsc_pkg::ADDR_STATUS) || (a == mcsc_pkg::ADDR_MASK) ||
                      (a == mcsc_pkg::ADDR_LIVE);
    endfunction

    // magnitude of a signed 32-bit value
    function automatic logic [31:0] mcsc_abs(input logic [31:0] v);
        mcsc_abs = v[31] ? (~v + 32'h00000001) : v;
    endfunction

    // ==========================================================
    // combinational decode
    logic        wr_en;
    logic        rd_setup;
    logic [1:0]  goal_sel;
    logic [1:0]  cmp_op;
    logic [3:0]  trig;
    logic        start_pol;
    logic [31:0] cmp_pos;
    logic [31:0] cmp_operand;
    logic [33:0] raw_x;
    logic [33:0] rng_x;
    logic [33:0] wrap_x;
    logic        zone_now;
    logic        start_active;
    logic        ext_trig;
    logic        trig_any;
    logic [3:0]  clr_bits;
    logic [3:0]  set_bits;

    // apb handshake: zero wait states, error on unmapped address
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mcsc_mapped(paddr);
    assign wr_en   = psel & penable & pwrite & mcsc_mapped(paddr);
    assign rd_setup = psel & ~penable & ~pwrite;

    // configuration fields
    assign goal_sel  = s.ref_cfg[mcsc_pkg::GOAL_SEL_LSB +: 2];
    assign cmp_op    = s.ref_cfg[mcsc_pkg::CMP_OP_LSB +: 2];
    assign trig      = s.start_cfg[mcsc_pkg::TRIG_LSB +: 4];
    assign start_pol = s.start_cfg[mcsc_pkg::START_POL_BIT];

    // comparator position source
    assign cmp_pos = s.ref_cfg[mcsc_pkg::CMP_SRC_BIT] ? s.enc_pos : actual_position;

    // comparator operand
    always_comb begin
        case (cmp_op)
            2'h0:    cmp_operand = compare_value;
            2'h1:    cmp_operand = home_position;
            2'h2:    cmp_operand = s.ref_cfg[mcsc_pkg::CMP_SRC_BIT] ? encoder_latched : latched_position;
            2'h3:    cmp_operand = revolution_counter;
            default: cmp_operand = compare_value;
        endcase
    end

    // encoder wrap into minus range .. range minus one
    assign raw_x = {{2{encoder_raw[31]}}, encoder_raw};
    assign rng_x = {2'b00, wrap_range};
    always_comb begin
        if (!s.ref_cfg[mcsc_pkg::ENC_WRAP_BIT]) begin
            wrap_x = raw_x;
        end else if ($signed(raw_x) >= $signed(rng_x)) begin
            wrap_x = raw_x - (rng_x + rng_x);
        end else if ($signed(raw_x) < -$signed(rng_x)) begin
            wrap_x = raw_x + (rng_x + rng_x);
        end else begin
            wrap_x = raw_x;
        end
    end

    // velocity magnitude at or above the datagram switch velocity
    assign zone_now = mcsc_abs(actual_velocity) >= datagram_switch_velocity;

    // start pin active level and trigger sources
    assign start_active = start_pol ? s.start_sync : ~s.start_sync;
    assign ext_trig     = trig[0] & start_active & ~s.start_prev;
    assign trig_any     = (trig != 4'h0) & (ext_trig |
                          (trig[1] & goal_event) |
                          (trig[2] & velocity_event) |
                          (trig[3] & s.cmp_event));

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        set_bits = 4'h0;
        clr_bits = 4'h0;

        // register writes take effect in the access phase
        if (wr_en && paddr == mcsc_pkg::ADDR_REF_CFG) begin
            next_s.ref_cfg = pwdata;
        end
        if (wr_en && paddr == mcsc_pkg::ADDR_START_CFG) begin
            next_s.start_cfg = pwdata;
        end
        if (wr_en && paddr == mcsc_pkg::ADDR_MASK) begin
            next_s.mask = pwdata[3:0];
        end
        if (wr_en && paddr == mcsc_pkg::ADDR_STATUS) begin
            clr_bits = pwdata[3:0];
        end

        // read data captured in the setup phase
        if (rd_setup) begin
            case (paddr)
                mcsc_pkg::ADDR_REF_CFG:   next_s.rdata = s.ref_cfg;
                mcsc_pkg::ADDR_START_CFG: next_s.rdata = s.start_cfg;
                mcsc_pkg::ADDR_STATUS:    next_s.rdata = {28'h0000000, s.status};
                mcsc_pkg::ADDR_MASK:      next_s.rdata = {28'h0000000, s.mask};
                mcsc_pkg::ADDR_LIVE:      next_s.rdata = {26'h0000000, s.pin_out, start_active,
                                                          s.cover_zone, s.stall_active,
                                                          s.cmp_flag, s.goal_out};
                default:                  next_s.rdata = 32'h00000000;
            endcase
        end

        // encoder position
        next_s.enc_pos = wrap_x[31:0];

        // comparator flag and its rising edge event
        next_s.cmp_flag  = (cmp_pos == cmp_operand);
        next_s.cmp_event = next_s.cmp_flag & ~s.cmp_flag;
        if (next_s.cmp_event) begin
            set_bits[mcsc_pkg::ST_CMP_HIT] = 1'b1;
        end

        // goal pin source
        case (goal_sel)
            2'h0:    next_s.goal_out = goal_flag;
            2'h1:    next_s.goal_out = velocity_flag;
            2'h2:    next_s.goal_out = encoder_fail_flag;
            2'h3:    next_s.goal_out = s.cmp_flag;
            default: next_s.goal_out = goal_flag;
        endcase

        // stall stop: pulse a hard stop and hold the stop state
        next_s.hard_stop = stall_event & s.ref_cfg[mcsc_pkg::STALL_STOP_BIT];
        if (next_s.hard_stop) begin
            set_bits[mcsc_pkg::ST_STALL] = 1'b1;
        end

        // cover datagram on each crossing of the switch velocity
        next_s.cover_zone = zone_now;
        next_s.cover_req  = s.ref_cfg[mcsc_pkg::AUTO_COVER_BIT] & (zone_now ^ s.cover_zone);
        if (next_s.cover_req) begin
            set_bits[mcsc_pkg::ST_COVER] = 1'b1;
        end

        // start pin synchroniser and trigger
        next_s.start_meta  = start_pin_in;
        next_s.start_sync  = s.start_meta;
        next_s.start_prev  = start_active;
        next_s.start_pulse = trig_any;
        next_s.pin_out     = start_pol ? trig_any : ~trig_any;
        if (trig_any) begin
            set_bits[mcsc_pkg::ST_START] = 1'b1;
        end

        // sticky status: a new event wins over a clear
        next_s.status = (s.status & ~clr_bits) | set_bits;

        // stop state ends when software clears its status bit
        if (next_s.hard_stop) begin
            next_s.stall_active = 1'b1;
        end else if (clr_bits[mcsc_pkg::ST_STALL]) begin
            next_s.stall_active = 1'b0;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s              <= '0;
            s.ref_cfg      <= mcsc_pkg::REF_CFG_RST;
            s.start_cfg    <= mcsc_pkg::START_CFG_RST;
            s.status       <= mcsc_pkg::STATUS_RST;
            s.mask         <= mcsc_pkg::MASK_RST;
            s.pin_out      <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs
    assign prdata               = s.rdata;
    assign encoder_position     = s.enc_pos;
    assign comparator_hit_flag  = s.cmp_flag;
    assign comparator_hit_event = s.cmp_event;
    assign goal_pin             = s.goal_out;
    assign spi_hard_stop        = s.hard_stop;
    assign step_hard_stop       = s.hard_stop;
    assign cover_request        = s.cover_req;

    // motion blocked while stopped unless driving after a stall is allowed
    assign motion_enable = ~s.stall_active | s.ref_cfg[mcsc_pkg::DRV_AFTER_BIT];

    // parameter hold bits and shadow enable
    assign change_needs_start = s.start_cfg[mcsc_pkg::START_EN_LSB +: 4];
    assign shadow_enable      = s.start_cfg[mcsc_pkg::SHADOW_BIT];

    // timing features live only with some trigger selected
    assign timing_enable = (trig != 4'h0);
    assign start_trigger = s.start_pulse;

    // start pin drives only as output with a trigger source selected
    assign start_pin_out  = s.pin_out;
    assign start_pin_oe_n = ~((trig != 4'h0) & ~trig[0]);

    // level interrupt from unmasked sticky status
    assign irq = |(s.status & s.mask);

endmodule

/* File: tb/mcsc_core_sva.sv */
/* concurrent checks on the mcsc_core ports, bound into every instance.
   assumes one clock ref_clk, async active low rst_n and pready tied high. */
`timescale 1ns/1ps
module mcsc_core_sva (
    // clock, reset and apb
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // causes
    input wire logic [31:0] encoder_raw,
    input wire logic        goal_event,
    input wire logic        velocity_event,
    input wire logic        stall_event,
    // outputs under check
    input wire logic [31:0] encoder_position,
    input wire logic        spi_hard_stop,
    input wire logic        step_hard_stop,
    input wire logic        motion_enable,
    input wire logic [3:0]  change_needs_start,
    input wire logic        shadow_enable,
    input wire logic        timing_enable,
    input wire logic        start_trigger,
    input wire logic        start_pin_oe_n,
    input wire logic        comparator_hit_flag,
    input wire logic        comparator_hit_event
);
    logic [31:0] sh_ref, sh_start, rd_exp;
    logic [3:0]  trig;
    logic        out_mode;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // shadow copies of both configuration registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_ref   <= 32'h00000000;
            sh_start <= 32'h00000000;
        end else if (psel && penable && pwrite) begin
            if (paddr == mcsc_pkg::ADDR_REF_CFG) sh_ref <= pwdata;
            if (paddr == mcsc_pkg::ADDR_START_CFG) sh_start <= pwdata;
        end
    end
    // expected read data and start pin direction
    assign rd_exp   = (paddr == mcsc_pkg::ADDR_REF_CFG) ? sh_ref : sh_start;
    assign trig     = sh_start[8:5];
    assign out_mode = (trig != 4'h0) && !trig[0];
    // ==========================================================
    // sequences and properties
    sequence s_rd_setup;
        psel && !penable && !pwrite && (paddr == mcsc_pkg::ADDR_REF_CFG || paddr == mcsc_pkg::ADDR_START_CFG);
    endsequence
    sequence s_stall_stop;
        stall_event && sh_ref[26] && !sh_ref[27] ##1 1'b1;
    endsequence
    property p_rd; s_rd_setup |=> prdata == $past(rd_exp); endproperty
    property p_cfg; change_needs_start == sh_start[3:0] && shadow_enable == sh_start[4]; endproperty
    property p_timing; timing_enable == (trig != 4'h0) and ((trig == 4'h0) |=> !start_trigger); endproperty
    property p_oe; $stable(trig) |-> start_pin_oe_n == !out_mode; endproperty
    property p_stall; stall_event |=> spi_hard_stop == $past(sh_ref[26]) && step_hard_stop == spi_hard_stop; endproperty
    property p_motion; (s_stall_stop |-> !motion_enable) and (sh_ref[27] |-> motion_enable); endproperty
    property p_wrap; !sh_ref[31] |=> encoder_position == $past(encoder_raw); endproperty
    property p_trig; (goal_event && trig[1]) || (velocity_event && trig[2]) |=> start_trigger; endproperty
    property p_cmp_evt; comparator_hit_event == (comparator_hit_flag && !$past(comparator_hit_flag)); endproperty
    a_rd: assert property (p_rd) else $error("config readback differs");
    a_cfg: assert property (p_cfg) else $error("start enables differ");
    a_timing: assert property (p_timing) else $error("timing enable wrong");
    a_oe: assert property (p_oe) else $error("start pin direction wrong");
    a_stall: assert property (p_stall) else $error("hard stop wrong");
    a_motion: assert property (p_motion) else $error("motion gate wrong");
    a_wrap: assert property (p_wrap) else $error("encoder not passed through");
    a_trig: assert property (p_trig) else $error("start trigger missing");
    a_cmp_evt: assert property (p_cmp_evt) else $error("comparator event not on flag rise");
endmodule
bind mcsc_core mcsc_core_sva chk_u (.*);

/* File: tb/mcsc_drv_model.sv */
/* far-side model: motor driver counting stops and cover datagrams,
   and the external start source; resolves the start wire level. */
`timescale 1ns/1ps
module mcsc_drv_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // driver requests
    input wire logic spi_hard_stop,
    input wire logic step_hard_stop,
    input wire logic cover_request,
    // start line
    input wire logic start_req,
    input wire logic start_pol,
    input wire logic start_pin_out,
    input wire logic start_pin_oe_n,
    output logic     start_pin_in
);
    int n_stop;
    int n_cover;
    // count stops seen on both paths and cover datagrams
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            n_stop  <= 0;
            n_cover <= 0;
        end else begin
            n_stop  <= n_stop + int'(spi_hard_stop && step_hard_stop);
            n_cover <= n_cover + int'(cover_request === 1'b1);
        end
    end
    // device drives when enabled, else the external source holds its level
    assign start_pin_in = start_pin_oe_n ? (start_req ~^ start_pol) : start_pin_out;
endmodule

/* File: tb/test_mcsc_core.sv */
/* self-checking bench for mcsc_core over apb with a driver model.
   assumes the checker binds itself and the package is compiled first. */
`timescale 1ns/1ps
module test_mcsc_core;
    logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, actual_position, encoder_raw, wrap_range, compare_value;
    logic [31:0] home_position, latched_position, encoder_latched, revolution_counter, encoder_position;
    logic [31:0] actual_velocity, datagram_switch_velocity;
    logic        comparator_hit_flag, comparator_hit_event, goal_flag, velocity_flag, encoder_fail_flag;
    logic        goal_event, velocity_event, goal_pin, stall_event, spi_hard_stop, step_hard_stop;
    logic        motion_enable, cover_request, shadow_enable, timing_enable, start_trigger;
    logic [3:0]  change_needs_start;
    logic        start_pin_in, start_pin_out, start_pin_oe_n, irq, start_req, start_pol;
    int          n_fail, tests_run, n_trig, et, k;
    mcsc_core dut_u (.*);
    mcsc_drv_model drv_u (.*);
    // ==========================================================
    // clock, trigger counter and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) n_trig <= n_trig + int'(start_trigger === 1'b1);
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        tk(1);
        penable <= 1'b1;
        tk(1);
        while (pready !== 1'b1) tk(1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        tk(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask
    task automatic pulse(input logic [2:0] v);
        {stall_event, velocity_event, goal_event} <= v;
        tk(1);
        {stall_event, velocity_event, goal_event} <= 3'h0;
        tk(1);
    endtask
    task automatic encw(input logic [31:0] raw, input logic [31:0] exp);
        encoder_raw <= raw;
        tk(2);
        chk(encoder_position, exp);
    endtask
    task automatic report_and_stop();
        $display("tests_run %0d n_fail %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, goal_flag, velocity_flag, encoder_fail_flag} = '0;
        {goal_event, velocity_event, stall_event, actual_velocity, start_req, start_pol} = '0;
        {actual_position, encoder_raw, compare_value, home_position} = {32'h1, 32'h2, 32'h5, 32'h6};
        {latched_position, encoder_latched, revolution_counter} = {32'h7, 32'h8, 32'h9};
        {wrap_range, datagram_switch_velocity} = {32'd100, 32'd100};
        tk(4);
        rst_n <= 1'b1;
        tk(1);
        // reset values, readback and an unmapped place
        rdc(mcsc_pkg::ADDR_REF_CFG, 32'h00000000);
        rdc(mcsc_pkg::ADDR_START_CFG, 32'h00000000);
        wr(mcsc_pkg::ADDR_REF_CFG, 32'hFF800000);
        rdc(mcsc_pkg::ADDR_REF_CFG, 32'hFF800000);
        apb(1'b0, 8'h40, 32'h00000000);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("done: registers");
        // start enables, direction per trigger bit, disabled timing
        for (k = 0; k < 4; k++) begin
            wr(mcsc_pkg::ADDR_START_CFG, 32'h1F | (32'h20 << k));
            tk(1);
            chk({change_needs_start, shadow_enable, timing_enable}, 6'h3F);
            chk(start_pin_oe_n, k == 0);
        end
        wr(mcsc_pkg::ADDR_START_CFG, 32'h1F);
        et = n_trig;
        pulse(3'b011);
        tk(2);
        chk({timing_enable, start_pin_oe_n, 30'(n_trig)}, {2'b01, 30'(et)});
        $display("done: start config");
        // goal pin sources, comparator operands and sources
        for (k = 0; k < 3; k++) begin
            wr(mcsc_pkg::ADDR_REF_CFG, 32'(k) << 23);
            {encoder_fail_flag, velocity_flag, goal_flag} <= ~(3'b001 << k);
            tk(2);
            chk(goal_pin, 1'b0);
            {encoder_fail_flag, velocity_flag, goal_flag} <= 3'b001 << k;
            tk(2);
            chk(goal_pin, 1'b1);
        end
        for (k = 0; k < 4; k++) begin
            wr(mcsc_pkg::ADDR_REF_CFG, (32'(k) << 28) | 32'h01800000);
            actual_position <= 32'(k == 3 ? 9 : 5 + k);
            tk(3);
            chk({comparator_hit_flag, goal_pin}, 2'b11);
            actual_position <= 32'h1;
            tk(3);
            chk(comparator_hit_flag, 1'b0);
        end
        wr(mcsc_pkg::ADDR_REF_CFG, 32'h22000000);
        encoder_raw <= 32'h8;
        tk(4);
        chk(comparator_hit_flag, 1'b1);
        $display("done: compare");
        // encoder wrap folds both ways, keeps top of range, off passes
        wr(mcsc_pkg::ADDR_REF_CFG, 32'h80000000);
        encw(32'd150, 32'hFFFFFFCE);
        encw(32'hFFFFFF6A, 32'h00000032);
        encw(32'd99, 32'd99);
        wr(mcsc_pkg::ADDR_REF_CFG, 32'h00000000);
        encw(32'd150, 32'd150);
        $display("done: encoder");
        // stall stop, interrupt mask and clear, drive after stall
        wr(mcsc_pkg::ADDR_STATUS, 32'hF);
        wr(mcsc_pkg::ADDR_REF_CFG, 32'h04000000);
        stall_event <= 1'b1;
        tk(1);
        stall_event <= 1'b0;
        @(negedge ref_clk);
        chk({spi_hard_stop, step_hard_stop, motion_enable, irq}, 4'b1100);
        tk(1);
        wr(mcsc_pkg::ADDR_MASK, 32'h2);
        chk(irq, 1'b1);
        rdc(mcsc_pkg::ADDR_STATUS, 32'h2);
        wr(mcsc_pkg::ADDR_STATUS, 32'h2);
        chk({motion_enable, irq}, 2'b10);
        wr(mcsc_pkg::ADDR_REF_CFG, 32'h0C000000);
        pulse(3'b100);
        chk(motion_enable, 1'b1);
        wr(mcsc_pkg::ADDR_REF_CFG, 32'h00000000);
        pulse(3'b100);
        chk(drv_u.n_stop, 32'd2);
        $display("done: stall");
        // cover datagrams only on a threshold crossing while enabled
        wr(mcsc_pkg::ADDR_REF_CFG, 32'h40000000);
        actual_velocity <= 32'd200;
        tk(4);
        actual_velocity <= 32'hFFFFFF38;
        tk(4);
        actual_velocity <= 32'd0;
        tk(4);
        wr(mcsc_pkg::ADDR_REF_CFG, 32'h00000000);
        actual_velocity <= 32'd200;
        tk(4);
        chk(drv_u.n_cover, 32'd2);
        $display("done: cover");
        // internal start triggers with both polarities, external start trigger with active high polarity only
        wr(mcsc_pkg::ADDR_STATUS, 32'hF);
        wr(mcsc_pkg::ADDR_MASK, 32'h8);
        wr(mcsc_pkg::ADDR_START_CFG, 32'h0C0);
        tk(1);
        chk({start_pin_oe_n, start_pin_out, irq}, 3'b010);
        et = n_trig;
        pulse(3'b001);
        pulse(3'b010);
        tk(2);
        chk({irq, 31'(n_trig)}, {1'b1, 31'(et + 2)});
        wr(mcsc_pkg::ADDR_START_CFG, 32'h040);
        pulse(3'b010);
        tk(2);
        chk(n_trig, et + 2);
        wr(mcsc_pkg::ADDR_START_CFG, 32'h300);
        tk(2);
        chk(start_pin_out, 1'b0);
        actual_position <= 32'h5;
        tk(5);
        chk(n_trig, et + 3);
        start_pol <= 1'b1;
        wr(mcsc_pkg::ADDR_START_CFG, 32'h220);
        start_req <= 1'b1;
        tk(3);
        start_req <= 1'b0;
        tk(6);
        chk({start_pin_oe_n, 31'(n_trig)}, {1'b1, 31'(et + 4)});
        rdc(mcsc_pkg::ADDR_LIVE, 32'h0000000A);
        $display("done: start triggers");
        report_and_stop();
    end
endmodule
